/* common/mic_pkg.sv */
// Shared constants for the interrupt controller and its core end
`default_nettype none
package mic_pkg;
  // ==========================================
  // Sizes
  localparam int EXT_N       = 4;
  localparam int CMP_N       = 2;
  localparam int GRP_N       = 5;
  localparam int GRP_MEMB    = 4;
  localparam int VEC_N       = 12;
  localparam int IDX_W       = 4;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  // ==========================================
  // Register addresses on the core side
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAG_LO = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_FLAG_HI = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EN_LO   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_EN_HI   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_EDGE    = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_GRP0    = 4'h6;
  // ==========================================
  // Field positions and reset values
  localparam int GIE_BIT      = 0;
  localparam int GRP_FLAG_LSB = 4;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] MASK_FULL  = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_SER2  = 8'h33;
  localparam logic [DATA_W-1:0] MASK_SER3  = 8'h77;
  localparam int GRP_TIMER  = 3;
  localparam int GRP_SERIAL = 4;
  // ==========================================
  // Vector indices, lowest index is highest priority
  localparam int IDX_EXT0 = 0;
  localparam int IDX_EXT1 = 1;
  localparam int IDX_CMP0 = 2;
  localparam int IDX_CMP1 = 3;
  localparam int IDX_ADC  = 4;
  localparam int IDX_GRP0 = 5;
  localparam int IDX_EXT2 = 10;
  localparam int IDX_EXT3 = 11;
  // ==========================================
  // Vector addresses
  localparam int VEC_BASE   = 16'h0004;
  localparam int VEC_STRIDE = 16'h0004;
endpackage
`default_nettype wire

/* common/mic_if.sv */
// Link between the interrupt controller and the core end
`default_nettype none
interface mic_if;
  logic [mic_pkg::ADDR_W-1:0] reg_addr;
  logic [mic_pkg::DATA_W-1:0] reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [mic_pkg::DATA_W-1:0] reg_rdata;
  logic                       irq_req;
  logic [mic_pkg::IDX_W-1:0]  irq_idx;
  logic                       irq_ack;
  logic [mic_pkg::IDX_W-1:0]  ack_idx;
  logic                       stack_full;
  logic                       wake;

  modport dev (
    input  reg_addr,
    input  reg_wdata,
    input  reg_wr,
    input  reg_rd,
    output reg_rdata,
    output irq_req,
    output irq_idx,
    input  irq_ack,
    input  ack_idx,
    input  stack_full,
    output wake
  );

  modport core (
    output reg_addr,
    output reg_wdata,
    output reg_wr,
    output reg_rd,
    input  reg_rdata,
    input  irq_req,
    input  irq_idx,
    output irq_ack,
    output ack_idx,
    output stack_full,
    input  wake
  );
endinterface
`default_nettype wire

/* logic/mic_irq_ctrl.sv */
// Interrupt controller: request flags, enables, groups and vectoring
// What this block does
// - Source event sets its flag regardless of enable
// - Vector only when flag and enable set
// - Cleared global enable suppresses every vector
// - Accept pushes next address, loads vector address
// - Return instruction pops saved address from stack
// - Acceptance clears the global enable in hardware
// - Requests while blocked stay latched for later
// - Software re-sets global enable to allow nesting
// - Full stack holds off acceptance, request stays pending
// - Any flag newly set by a source event wakes sleep or idle
// - Each external pin edge sets its flag
// - Edge select: rising, falling, both or off
// - Software prepares enable, pin share, input direction
// - Servicing external interrupt clears its pin flag
// - Comparator output change sets comparator flag
// - Servicing comparator interrupt clears its flag
// - Five shared groups fed by member sources
// - Member request sets group flag; group vectors
// - Group service clears group flag, members stay
// - Timer group register: flags 7:4, enables 3:0
// - Two-port serial register: flags 5:4, enables 1:0
// - Three-port adds flag bit 6, enable bit 2
// - Servicing conversion interrupt clears its flag
`default_nettype none
module mic_irq_ctrl #(
  parameter bit THREE_PORT = 1'b1
) (
  input  wire logic                              REF_CLK_IN,
  input  wire logic                              ARST_N_IN,
  mic_if.dev                                     BUS,
  input  wire logic [mic_pkg::EXT_N-1:0]         EXT_PIN_IN,
  input  wire logic [mic_pkg::CMP_N-1:0]         CMP_LEVEL_IN,
  input  wire logic                              ADC_DONE_IN,
  input  wire logic [mic_pkg::GRP_N*mic_pkg::GRP_MEMB-1:0] GRP_EVT_IN,
  output logic                                   GIE_OUT,
  output logic                                   WAKE_OUT,
  output logic                                   IRQ_PENDING_OUT
);
  localparam int VN = mic_pkg::VEC_N;
  localparam int DW = mic_pkg::DATA_W;
  localparam int GM = mic_pkg::GRP_MEMB;

  logic [VN-1:0]                 flag_reg;
  logic [VN-1:0]                 flag_next;
  logic [VN-1:0]                 en_reg;
  logic                          gie_reg;
  logic [2*mic_pkg::EXT_N-1:0]   edge_reg;
  logic [DW-1:0]                 grp_reg [mic_pkg::GRP_N];
  logic [mic_pkg::EXT_N-1:0]     pin_prev_reg;
  logic [mic_pkg::CMP_N-1:0]     cmp_prev_reg;
  logic                          armed_reg;
  logic [mic_pkg::EXT_N-1:0]     ext_evt;
  logic [mic_pkg::CMP_N-1:0]     cmp_evt;
  logic [mic_pkg::GRP_N-1:0]     grp_evt;
  logic [VN-1:0]                 set_vec;
  logic [VN-1:0]                 cand;
  logic [mic_pkg::IDX_W-1:0]     pick;
  logic                          req_reg;
  logic [mic_pkg::IDX_W-1:0]     idx_reg;
  logic                          wake_reg;
  logic [DW-1:0]                 rdata_reg;
  logic [DW-1:0]                 grp_rd;

  // ==========================================
  // Write decode
  wire logic wr_ctrl = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_CTRL);
  wire logic wr_flo  = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_FLAG_LO);
  wire logic wr_fhi  = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_FLAG_HI);
  wire logic wr_elo  = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_EN_LO);
  wire logic wr_ehi  = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_EN_HI);
  wire logic wr_edge = BUS.reg_wr && (BUS.reg_addr == mic_pkg::ADDR_EDGE);

  // ==========================================
  // Edge detection on pins and comparator outputs
  // Armed one cycle after reset so a high level is not taken as an edge
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      armed_reg    <= 1'b0;
      pin_prev_reg <= '0;
      cmp_prev_reg <= '0;
    end else begin
      armed_reg    <= 1'b1;
      pin_prev_reg <= EXT_PIN_IN;
      cmp_prev_reg <= CMP_LEVEL_IN;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < mic_pkg::EXT_N; gi++) begin : g_ext
      logic rise;
      logic fall;
      assign rise = armed_reg && EXT_PIN_IN[gi] && !pin_prev_reg[gi];
      assign fall = armed_reg && !EXT_PIN_IN[gi] && pin_prev_reg[gi];
      assign ext_evt[gi] =
        (edge_reg[2*gi+mic_pkg::EDGE_RISE_BIT] && rise) ||
        (edge_reg[2*gi+mic_pkg::EDGE_FALL_BIT] && fall);
    end
    for (gi = 0; gi < mic_pkg::CMP_N; gi++) begin : g_cmp
      assign cmp_evt[gi] = armed_reg &&
        (CMP_LEVEL_IN[gi] != cmp_prev_reg[gi]);
    end
    // ==========================================
    // Shared groups: member flags at 7:4, member enables at 3:0
    for (gi = 0; gi < mic_pkg::GRP_N; gi++) begin : g_grp
      logic [DW-1:0] mask;
      logic [DW-1:0] memb_set;
      logic          wr_g;
      assign mask = (gi == mic_pkg::GRP_SERIAL) ?
                    (THREE_PORT ? mic_pkg::MASK_SER3 : mic_pkg::MASK_SER2) :
                    mic_pkg::MASK_FULL;
      assign memb_set = {GRP_EVT_IN[gi*GM +: GM], {GM{1'b0}}} & mask;
      assign wr_g = BUS.reg_wr &&
        (BUS.reg_addr == mic_pkg::ADDR_GRP0 + mic_pkg::ADDR_W'(gi));
      // Member event raises group flag when that member is enabled
      assign grp_evt[gi] = |(GRP_EVT_IN[gi*GM +: GM] &
        grp_reg[gi][GM-1:0] & mask[GM-1:0]);
      always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
          grp_reg[gi] <= mic_pkg::RESET_BYTE;
        end else begin
          // Member flags survive service, hardware set beats write
          grp_reg[gi] <= ((wr_g ? BUS.reg_wdata : grp_reg[gi]) |
                          memb_set) & mask;
        end
      end
    end
  endgenerate
  // ==========================================
  // Request flags
  always_comb begin
    set_vec = '0;
    set_vec[mic_pkg::IDX_EXT0] = ext_evt[0];
    set_vec[mic_pkg::IDX_EXT1] = ext_evt[1];
    set_vec[mic_pkg::IDX_EXT2] = ext_evt[2];
    set_vec[mic_pkg::IDX_EXT3] = ext_evt[3];
    set_vec[mic_pkg::IDX_CMP0] = cmp_evt[0];
    set_vec[mic_pkg::IDX_CMP1] = cmp_evt[1];
    set_vec[mic_pkg::IDX_ADC]  = ADC_DONE_IN;
    set_vec[mic_pkg::IDX_GRP0 +: mic_pkg::GRP_N] = grp_evt;
  end
  always_comb begin
    flag_next = flag_reg;
    if (wr_flo) begin
      flag_next[DW-1:0] = BUS.reg_wdata;
    end
    if (wr_fhi) begin
      flag_next[VN-1:DW] = BUS.reg_wdata[VN-DW-1:0];
    end
    // Service clears only the accepted vector's own flag
    if (BUS.irq_ack) begin
      flag_next[BUS.ack_idx] = 1'b0;
    end
    // Set wins over any clear in the same cycle, enable not involved
    flag_next = flag_next | set_vec;
  end
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      en_reg   <= '0;
      edge_reg <= '0;
    end else begin
      if (wr_elo) begin
        en_reg[DW-1:0] <= BUS.reg_wdata;
      end
      if (wr_ehi) begin
        en_reg[VN-1:DW] <= BUS.reg_wdata[VN-DW-1:0];
      end
      if (wr_edge) begin
        edge_reg <= BUS.reg_wdata;
      end
    end
  end

  // ==========================================
  // Global enable
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      gie_reg <= 1'b0;
    end else if (BUS.irq_ack) begin
      gie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      gie_reg <= BUS.reg_wdata[mic_pkg::GIE_BIT];
    end
  end

  // ==========================================
  // Priority pick and request to the core
  assign cand = flag_reg & en_reg;
  always_comb begin
    pick = '0;
    for (int i = VN - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick = mic_pkg::IDX_W'(i);
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      req_reg <= 1'b0;
      idx_reg <= '0;
    end else begin
      // Dropped the cycle after the core acknowledges
      req_reg <= gie_reg && (|cand) && !BUS.stack_full &&
                 !BUS.irq_ack;
      idx_reg <= pick;
    end
  end

  // ==========================================
  // Wake on any flag newly set by a source event, not by a register write
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= |(set_vec & ~flag_reg);
    end
  end

  // ==========================================
  // Read back
  always_comb begin
    grp_rd = mic_pkg::RESET_BYTE;
    for (int g = 0; g < mic_pkg::GRP_N; g++) begin
      if (BUS.reg_addr == mic_pkg::ADDR_GRP0 + mic_pkg::ADDR_W'(g)) begin
        grp_rd = grp_reg[g];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_reg <= mic_pkg::RESET_BYTE;
    end else if (BUS.reg_rd) begin
      if (BUS.reg_addr == mic_pkg::ADDR_CTRL) begin
        rdata_reg <= {{(DW-1){1'b0}}, gie_reg};
      end else if (BUS.reg_addr == mic_pkg::ADDR_FLAG_LO) begin
        rdata_reg <= flag_reg[DW-1:0];
      end else if (BUS.reg_addr == mic_pkg::ADDR_FLAG_HI) begin
        rdata_reg <= {{(2*DW-VN){1'b0}}, flag_reg[VN-1:DW]};
      end else if (BUS.reg_addr == mic_pkg::ADDR_EN_LO) begin
        rdata_reg <= en_reg[DW-1:0];
      end else if (BUS.reg_addr == mic_pkg::ADDR_EN_HI) begin
        rdata_reg <= {{(2*DW-VN){1'b0}}, en_reg[VN-1:DW]};
      end else if (BUS.reg_addr == mic_pkg::ADDR_EDGE) begin
        rdata_reg <= edge_reg;
      end else begin
        rdata_reg <= grp_rd;
      end
    end else begin
      rdata_reg <= mic_pkg::RESET_BYTE;
    end
  end

  assign BUS.reg_rdata   = rdata_reg;
  assign BUS.irq_req     = req_reg;
  assign BUS.irq_idx     = idx_reg;
  assign BUS.wake        = wake_reg;
  assign GIE_OUT         = gie_reg;
  assign WAKE_OUT        = wake_reg;
  assign IRQ_PENDING_OUT = req_reg;
endmodule
`default_nettype wire

/* logic/mic_core_end.sv */
// Core end: program counter, return stack, sleep and vector acceptance
`default_nettype none
module mic_core_end #(
  parameter int PC_W  = mic_pkg::PC_W,
  parameter int DEPTH = mic_pkg::STACK_DEPTH
) (
  input  wire logic                       REF_CLK_IN,
  input  wire logic                       ARST_N_IN,
  mic_if.core                             BUS,
  input  wire logic [mic_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [mic_pkg::DATA_W-1:0] REG_WDATA_IN,
  input  wire logic                       REG_WR_IN,
  input  wire logic                       REG_RD_IN,
  output logic [mic_pkg::DATA_W-1:0]      REG_RDATA_OUT,
  input  wire logic                       STEP_IN,
  input  wire logic                       RET_IN,
  input  wire logic                       SLEEP_IN,
  output logic [PC_W-1:0]                 PC_OUT,
  output logic [$clog2(DEPTH+1)-1:0]      SP_OUT,
  output logic                            SLEEPING_OUT
);
  localparam int SP_W = $clog2(DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);
  localparam int SI_W = $clog2(DEPTH);

  logic [PC_W-1:0]          pc_reg;
  logic [PC_W-1:0]          stack_mem [DEPTH];
  logic [SP_W-1:0]          sp_reg;
  logic                     full_reg;
  logic                     sleep_reg;
  logic                     ack_reg;
  logic [mic_pkg::IDX_W-1:0] ack_idx_reg;
  logic                     accept;
  logic                     pop;
  logic [PC_W-1:0]          vec_addr;

  // Plain register port passes straight to the controller
  assign BUS.reg_addr  = REG_ADDR_IN;
  assign BUS.reg_wdata = REG_WDATA_IN;
  assign BUS.reg_wr    = REG_WR_IN;
  assign BUS.reg_rd    = REG_RD_IN;
  assign REG_RDATA_OUT = BUS.reg_rdata;

  // ==========================================
  // Acceptance
  // Never while the ack is up, since the request is still up then
  assign accept = BUS.irq_req && !ack_reg && !full_reg && !sleep_reg;
  assign pop    = RET_IN && !accept && (sp_reg != '0);
  assign vec_addr = PC_W'(mic_pkg::VEC_BASE) +
                    PC_W'(BUS.irq_idx) * PC_W'(mic_pkg::VEC_STRIDE);

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ack_reg     <= 1'b0;
      ack_idx_reg <= '0;
    end else begin
      ack_reg <= accept;
      if (accept) begin
        ack_idx_reg <= BUS.irq_idx;
      end
    end
  end

  // ==========================================
  // Program counter and stack
  always_ff @(posedge REF_CLK_IN) begin
    if (accept) begin
      stack_mem[sp_reg[SI_W-1:0]] <= pc_reg;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pc_reg   <= '0;
      sp_reg   <= '0;
      full_reg <= 1'b0;
    end else if (accept) begin
      pc_reg   <= vec_addr;
      sp_reg   <= sp_reg + SP_W'(1);
      full_reg <= (sp_reg + SP_W'(1)) == SP_FULL;
    end else if (pop) begin
      pc_reg   <= stack_mem[sp_reg[SI_W-1:0] - SI_W'(1)];
      sp_reg   <= sp_reg - SP_W'(1);
      full_reg <= 1'b0;
    end else if (STEP_IN && !sleep_reg) begin
      pc_reg <= pc_reg + PC_W'(1);
    end
  end

  // ==========================================
  // Sleep, left on any wake from the controller
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sleep_reg <= 1'b0;
    end else if (BUS.wake) begin
      sleep_reg <= 1'b0;
    end else if (SLEEP_IN) begin
      sleep_reg <= 1'b1;
    end
  end

  assign BUS.irq_ack    = ack_reg;
  assign BUS.ack_idx    = ack_idx_reg;
  assign BUS.stack_full = full_reg;
  assign PC_OUT         = pc_reg;
  assign SP_OUT         = sp_reg;
  assign SLEEPING_OUT   = sleep_reg;
endmodule
`default_nettype wire

/* tb/mic_irq_assertions.sv */
// Link checker between the interrupt controller and the core end
`default_nettype none
module mic_irq_assertions (
  input wire logic                       REF_CLK_IN,
  input wire logic                       ARST_N_IN,
  input wire logic [mic_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic                       reg_rd_in,
  input wire logic [mic_pkg::DATA_W-1:0] reg_rdata_in,
  input wire logic                       irq_req_in,
  input wire logic [mic_pkg::IDX_W-1:0]  irq_idx_in,
  input wire logic                       irq_ack_in,
  input wire logic [mic_pkg::IDX_W-1:0]  ack_idx_in,
  input wire logic                       stack_full_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Link properties
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  chk_unmapped_zero:
    assert property (reg_rd_in && reg_addr_in > 4'hA |=>
      reg_rdata_in == 8'h00)
    else $error("unmapped read not zero");
  chk_serial_mask:
    assert property (reg_rd_in && reg_addr_in == 4'hA |=>
      reg_rdata_in[7] == 1'b0 && reg_rdata_in[3] == 1'b0)
    else $error("serial group unused bits set");
  chk_ack_needs_req:
    assert property (irq_ack_in |-> $past(irq_req_in))
    else $error("accept without request");
  chk_ack_idx_match:
    assert property (irq_ack_in |-> ack_idx_in == $past(irq_idx_in))
    else $error("accepted index differs");
  chk_ack_one_cycle:
    assert property (irq_ack_in |=> !irq_ack_in)
    else $error("accept longer than a cycle");
  chk_ack_has_room:
    assert property (irq_ack_in |-> !$past(stack_full_in))
    else $error("accept on full stack");
  chk_full_holds_req:
    assert property ($past(stack_full_in) |-> !irq_req_in)
    else $error("request while stack full");
  chk_ack_drops_req:
    assert property (irq_ack_in |=> (!irq_req_in) [*2])
    else $error("request after accept");
  chk_vec_in_range:
    assert property (irq_req_in |-> irq_idx_in < mic_pkg::VEC_N)
    else $error("vector index out of range");
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Testbench joining the interrupt controller and the core end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CTL = mic_pkg::ADDR_CTRL;
  localparam logic [3:0] FLO = mic_pkg::ADDR_FLAG_LO;
  localparam logic [3:0] FHI = mic_pkg::ADDR_FLAG_HI;
  localparam logic [3:0] ELO = mic_pkg::ADDR_EN_LO;
  localparam logic [3:0] EHI = mic_pkg::ADDR_EN_HI;
  localparam logic [3:0] EDG = mic_pkg::ADDR_EDGE;
  localparam logic [3:0] GRP = mic_pkg::ADDR_GRP0;
  logic        ref_clk;
  logic        arst_n;
  logic [3:0]  ext_pin;
  logic [1:0]  cmp_lvl;
  logic        adc_done;
  logic [19:0] grp_evt;
  logic        gie;
  logic        pend;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  rdata;
  logic        ret;
  logic        sleep;
  logic [12:0] pc;
  logic [3:0]  sp;
  logic        sleeping;
  logic        wake;
  int          num_errors;
  int          cmp_count;
  mic_if bus_if ();
  mic_irq_ctrl #(.THREE_PORT(1'b1)) u_mic_irq_ctrl (
    .REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n), .BUS(bus_if),
    .EXT_PIN_IN(ext_pin), .CMP_LEVEL_IN(cmp_lvl), .ADC_DONE_IN(adc_done),
    .GRP_EVT_IN(grp_evt), .GIE_OUT(gie), .WAKE_OUT(wake),
    .IRQ_PENDING_OUT(pend));
  mic_core_end u_mic_core_end (
    .REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n), .BUS(bus_if),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s),
    .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .STEP_IN(1'b0),
    .RET_IN(ret), .SLEEP_IN(sleep), .PC_OUT(pc), .SP_OUT(sp),
    .SLEEPING_OUT(sleeping));
  // Two-port variant shares the register port, its core side held idle
  mic_if bus2_if ();
  assign bus2_if.reg_addr   = addr;
  assign bus2_if.reg_wdata  = wdata;
  assign bus2_if.reg_wr     = wr_s;
  assign bus2_if.reg_rd     = rd_s;
  assign bus2_if.irq_ack    = 1'b0;
  assign bus2_if.ack_idx    = 4'h0;
  assign bus2_if.stack_full = 1'b0;
  mic_irq_ctrl #(.THREE_PORT(1'b0)) u_mic_irq_ctrl_two (
    .REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n), .BUS(bus2_if),
    .EXT_PIN_IN(ext_pin), .CMP_LEVEL_IN(cmp_lvl), .ADC_DONE_IN(adc_done),
    .GRP_EVT_IN(grp_evt), .GIE_OUT(), .WAKE_OUT(),
    .IRQ_PENDING_OUT());
  mic_irq_assertions u_mic_irq_assertions (
    .REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n),
    .reg_addr_in(bus_if.reg_addr), .reg_rd_in(bus_if.reg_rd),
    .reg_rdata_in(bus_if.reg_rdata), .irq_req_in(bus_if.irq_req),
    .irq_idx_in(bus_if.irq_idx), .irq_ack_in(bus_if.irq_ack),
    .ack_idx_in(bus_if.ack_idx), .stack_full_in(bus_if.stack_full));
  // ==========================================
  // Shared tasks
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("wrong value at %0t: %s", $time, m);
    conclude();
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1;
    cmp(rdata, e, "read data");
  endtask
  task automatic evt(input logic a, input logic [19:0] g);
    @(posedge ref_clk);
    adc_done <= a;
    grp_evt <= g;
    @(posedge ref_clk);
    adc_done <= 1'b0;
    grp_evt <= 20'h0_0000;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
    cmp(pend, 1'b0, "no request");
  endtask
  task automatic take(input logic [12:0] pe, input logic [3:0] se);
    int n;
    n = 0;
    while (bus_if.irq_ack !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 30)
        fail("no accept");
    end
    cmp(pc, pe, "vector");
    cmp(sp, se, "depth");
    @(posedge ref_clk);
    #1;
    cmp(gie, 1'b0, "global enable");
  endtask
  task automatic pop(input logic [12:0] pe, input logic [3:0] se);
    @(posedge ref_clk);
    ret <= 1'b1;
    @(posedge ref_clk);
    ret <= 1'b0;
    #1;
    cmp(pc, pe, "return pc");
    cmp(sp, se, "return depth");
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs();
    for (int a = 0; a < 11; a++)
      rd(a[3:0], 8'h00);
    wr(4'hB, 8'hFF);
    rd(4'hB, 8'h00);
    wr(GRP + 4'h3, 8'hFF);
    rd(GRP + 4'h3, 8'hFF);
    wr(GRP + 4'h4, 8'hFF);
    rd(GRP + 4'h4, 8'h77);
    cmp(bus2_if.reg_rdata, 8'h33, "two-port mask");
    wr(GRP + 4'h3, 8'h00);
    wr(GRP + 4'h4, 8'h00);
  endtask
  task automatic t_adc();
    evt(1'b1, 20'h0_0000);
    rd(FLO, 8'h10);
    wr(CTL, 8'h01);
    idle(5);
    wr(CTL, 8'h00);
    wr(ELO, 8'h10);
    idle(5);
    wr(CTL, 8'h01);
    take(13'd20, 4'd1);
    rd(FLO, 8'h00);
    pop(13'd0, 4'd0);
    wr(ELO, 8'h00);
  endtask
  task automatic t_prio();
    @(posedge ref_clk);
    cmp_lvl <= 2'b11;
    wr(ELO, 8'h0C);
    wr(CTL, 8'h01);
    take(13'd12, 4'd1);
    rd(FLO, 8'h08);
    wr(CTL, 8'h01);
    take(13'd16, 4'd2);
    pop(13'd12, 4'd1);
    pop(13'd0, 4'd0);
    wr(ELO, 8'h00);
  endtask
  task automatic t_ext();
    wr(EDG, 8'h39);
    @(posedge ref_clk);
    ext_pin <= 4'hF;
    rd(FLO, 8'h01);
    rd(FHI, 8'h04);
    @(posedge ref_clk);
    ext_pin <= 4'h0;
    rd(FLO, 8'h03);
    rd(FHI, 8'h04);
    wr(ELO, 8'h02);
    wr(CTL, 8'h01);
    take(13'd8, 4'd1);
    rd(FLO, 8'h01);
    pop(13'd0, 4'd0);
    wr(FLO, 8'h00);
    wr(FHI, 8'h00);
    wr(ELO, 8'h00);
    wr(EDG, 8'h00);
  endtask
  task automatic t_grp();
    logic [11:0] fl;
    fl = 12'h000;
    for (int g = 0; g < 5; g++) begin
      wr(GRP + 4'(g), 8'h01);
      evt(1'b0, 20'h1 << (4 * g));
      fl[5 + g] = 1'b1;
      rd(GRP + 4'(g), 8'h11);
      rd(FLO, fl[7:0]);
      rd(FHI, {4'h0, fl[11:8]});
    end
    wr(EHI, 8'h01);
    wr(CTL, 8'h01);
    take(13'd36, 4'd1);
    rd(FHI, 8'h02);
    rd(GRP + 4'h3, 8'h11);
    pop(13'd0, 4'd0);
    for (int g = 0; g < 5; g++)
      wr(GRP + 4'(g), 8'h00);
    wr(FLO, 8'h00);
    wr(FHI, 8'h00);
    wr(EHI, 8'h00);
  endtask
  task automatic t_full();
    wr(ELO, 8'h10);
    for (int i = 0; i < 8; i++) begin
      evt(1'b1, 20'h0_0000);
      wr(CTL, 8'h01);
      take(13'd20, 4'(i + 1));
    end
    evt(1'b1, 20'h0_0000);
    wr(CTL, 8'h01);
    idle(10);
    cmp(sp, 4'd8, "full depth");
    pop(13'd20, 4'd7);
    take(13'd20, 4'd8);
    for (int i = 0; i < 8; i++)
      pop((i == 7) ? 13'd0 : 13'd20, 4'(7 - i));
    wr(ELO, 8'h00);
  endtask
  task automatic t_wake();
    int n;
    wr(FLO, 8'h10);
    @(posedge ref_clk);
    sleep <= 1'b1;
    @(posedge ref_clk);
    sleep <= 1'b0;
    evt(1'b1, 20'h0_0000);
    #1;
    cmp(wake, 1'b0, "preset flag no wake");
    idle(4);
    cmp(sleeping, 1'b1, "asleep");
    @(posedge ref_clk);
    cmp_lvl <= 2'b00;
    @(posedge ref_clk);
    #1;
    cmp(wake, 1'b1, "wake pulse");
    n = 0;
    while (sleeping !== 1'b0) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20)
        fail("no wake");
    end
    cmp(sleeping, 1'b0, "awake");
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    num_errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    ext_pin = 4'h0;
    cmp_lvl = 2'b00;
    adc_done = 1'b0;
    grp_evt = 20'h0_0000;
    addr = 4'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    ret = 1'b0;
    sleep = 1'b0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_adc();
    t_prio();
    t_ext();
    t_grp();
    t_full();
    t_wake();
    conclude();
  end
endmodule
`default_nettype wire
